// ---- hw/dbs_write_ctrl.sv ----
// Purpose: dynamic bus sizing sequencer for operand writes and prefetch checks
// Assumes: port answers each cycle on the two width acknowledge inputs
// Notes: software loads address and operand, then starts with a control write
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module dbs_write_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb register bus
    input wire dbs_pkg::dbs_apb_req_type apb_req,
    output dbs_pkg::dbs_apb_rsp_type apb_rsp,
    // external bus cycle
    output dbs_pkg::dbs_ext_out_type ext_out,
    input wire logic port_width_ack_upper,
    input wire logic port_width_ack_lower,
    // interrupt
    output logic irq
);
    import dbs_pkg::*;

    typedef enum logic [2:0] {
        DBS_IDLE = 3'b001,
        DBS_CYCLE = 3'b010,
        DBS_END = 3'b100
    } dbs_state_type;

    dbs_state_type state_q;
    dbs_state_type state_d;
    logic [31:0] addr_reg_q;
    logic [31:0] data_reg_q;
    logic [1:0] op_size_q;
    logic [31:0] operand_q;
    logic [31:0] cur_addr_q;
    logic [31:0] cur_addr_d;
    logic [2:0] rem_q;
    logic [2:0] rem_d;
    logic fetch_q;
    logic [7:0] cyc_cnt_q;
    logic [DBS_EV_WIDTH-1:0] stat_q;
    logic [DBS_EV_WIDTH-1:0] ien_q;
    logic [DBS_EV_WIDTH-1:0] ev;
    logic [31:0] prdata_q;
    logic apb_setup;
    logic apb_wr;
    logic [7:0] ofs;
    logic mapped;
    logic start_wr;
    logic start_fetch;
    logic [2:0] start_rem;
    logic fetch_odd;
    logic ack_any;
    logic [2:0] limit;
    logic [2:0] taken;
    logic [31:0] lanes;
    logic [31:0] misalign_flags;
    logic [31:0] mux_operand;

    // apb decode
    assign ofs = apb_req.paddr[7:0];
    assign apb_setup = apb_req.psel && !apb_req.penable;
    assign apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    always_comb begin
        case (ofs)
            DBS_OFS_CTRL, DBS_OFS_ADDR, DBS_OFS_DATA, DBS_OFS_STAT,
            DBS_OFS_CLR, DBS_OFS_IEN, DBS_OFS_STATE: mapped = (apb_req.paddr[31:8] == 24'h0);
            default: mapped = 1'b0;
        endcase
    end
    assign apb_rsp.pready = apb_req.psel && apb_req.penable;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
    assign apb_rsp.prdata = prdata_q;

    // start requests, ignored while a transfer runs
    assign start_wr = apb_wr && mapped && (ofs == DBS_OFS_CTRL)
        && apb_req.pwdata[DBS_CTRL_WRITE_BIT] && (state_q == DBS_IDLE);
    assign start_fetch = apb_wr && mapped && (ofs == DBS_OFS_CTRL)
        && apb_req.pwdata[DBS_CTRL_FETCH_BIT] && !apb_req.pwdata[DBS_CTRL_WRITE_BIT]
        && (state_q == DBS_IDLE);
    assign fetch_odd = start_fetch && addr_reg_q[0];

    // operand size to byte count, long word as four
    always_comb begin
        case (apb_req.pwdata[DBS_CTRL_SIZE_LSB +: 2])
            DBS_SIZE_BYTE: start_rem = 3'h1;
            DBS_SIZE_WORD: start_rem = 3'h2;
            DBS_SIZE_THREE: start_rem = 3'h3;
            default: start_rem = DBS_BYTES_LONG;
        endcase
    end

    // alignment classification, reported in the state register
    always_comb begin
        misalign_flags = 32'h0;
        case (op_size_q)
            DBS_SIZE_BYTE: misalign_flags[0] = 1'b0;
            DBS_SIZE_WORD: misalign_flags[0] = addr_reg_q[0];
            default: misalign_flags[0] = (addr_reg_q[1:0] != 2'h0);
        endcase
    end

    // bytes the port took this cycle, from its width acknowledge
    assign ack_any = port_width_ack_upper || port_width_ack_lower;
    always_comb begin
        if (port_width_ack_upper && port_width_ack_lower) begin
            limit = DBS_BYTES_LONG - {1'b0, cur_addr_q[1:0]};
        end else if (port_width_ack_upper) begin
            limit = DBS_BYTES_WORD_PORT - {2'b0, cur_addr_q[0]};
        end else begin
            limit = DBS_BYTES_BYTE_PORT;
        end
        taken = (rem_q < limit) ? rem_q : limit;
    end

    // sequencer
    always_comb begin
        state_d = state_q;
        rem_d = rem_q;
        cur_addr_d = cur_addr_q;
        case (state_q)
            DBS_IDLE: begin
                if ((start_wr || start_fetch) && !fetch_odd) begin
                    state_d = DBS_CYCLE;
                    rem_d = start_fetch ? DBS_BYTES_LONG : start_rem;
                    cur_addr_d = addr_reg_q;
                end
            end
            DBS_CYCLE: begin
                if (ack_any) begin
                    state_d = DBS_END;
                    rem_d = rem_q - taken;
                    cur_addr_d = cur_addr_q + {29'h0, taken};
                end
            end
            DBS_END: begin
                state_d = (rem_q == 3'h0) ? DBS_IDLE : DBS_CYCLE;
            end
            default: begin
                state_d = DBS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= DBS_IDLE;
            rem_q <= 3'h0;
            cur_addr_q <= DBS_RST_WORD;
        end else begin
            state_q <= state_d;
            rem_q <= rem_d;
            cur_addr_q <= cur_addr_d;
        end
    end

    // operand capture and cycle counter
    always_ff @(posedge clk) begin
        if (!rstn) begin
            operand_q <= DBS_RST_WORD;
            fetch_q <= 1'b0;
            cyc_cnt_q <= 8'h0;
        end else if (state_q == DBS_IDLE && (start_wr || start_fetch) && !fetch_odd) begin
            operand_q <= data_reg_q;
            fetch_q <= start_fetch;
            cyc_cnt_q <= 8'h0;
        end else if (state_q == DBS_CYCLE && ack_any) begin
            cyc_cnt_q <= cyc_cnt_q + 8'h1;
        end
    end

    // first cycle opens in the same edge that loads operand_q
    assign mux_operand = (state_q == DBS_IDLE) ? data_reg_q : operand_q;

    dbs_lane_mux u_lane_mux (
        .operand(mux_operand),
        .size(rem_d[1:0]),
        .offset(cur_addr_d[1:0]),
        .lanes(lanes)
    );

    // external cycle outputs, loaded as each cycle opens
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ext_out <= '0;
        end else if (state_d == DBS_CYCLE && state_q != DBS_CYCLE) begin
            ext_out.addr <= cur_addr_d;
            ext_out.size_code_high <= rem_d[1];
            ext_out.size_code_low <= rem_d[0];
            ext_out.byte_offset_high <= cur_addr_d[1];
            ext_out.byte_offset_low <= cur_addr_d[0];
            ext_out.cycle <= 1'b1;
            ext_out.read <= start_fetch || (fetch_q && state_q != DBS_IDLE);
            ext_out.data <= lanes;
            ext_out.data_oe <= !(start_fetch || (fetch_q && state_q != DBS_IDLE));
        end else if (state_q == DBS_CYCLE && ack_any) begin
            ext_out.cycle <= 1'b0;
            ext_out.data_oe <= 1'b0;
        end
    end

    // software registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            addr_reg_q <= DBS_RST_WORD;
            data_reg_q <= DBS_RST_WORD;
            op_size_q <= DBS_RST_SIZE;
            ien_q <= DBS_RST_EV;
        end else if (apb_wr && mapped) begin
            case (ofs)
                DBS_OFS_ADDR: addr_reg_q <= apb_req.pwdata;
                DBS_OFS_DATA: data_reg_q <= apb_req.pwdata;
                DBS_OFS_IEN: ien_q <= apb_req.pwdata[DBS_EV_WIDTH-1:0];
                DBS_OFS_CTRL: begin
                    if (state_q == DBS_IDLE) begin
                        op_size_q <= apb_req.pwdata[DBS_CTRL_SIZE_LSB +: 2];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // events: done in the end state after the last acknowledge, address error on odd prefetch
    always_comb begin
        ev = DBS_RST_EV;
        ev[DBS_EV_DONE_BIT] = (state_q == DBS_END) && (rem_q == 3'h0);
        ev[DBS_EV_ADDR_ERR_BIT] = fetch_odd;
    end

    // sticky status, a new event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            stat_q <= DBS_RST_EV;
        end else if (apb_wr && mapped && ofs == DBS_OFS_CLR) begin
            stat_q <= (stat_q & ~apb_req.pwdata[DBS_EV_WIDTH-1:0]) | ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    assign irq = |(stat_q & ien_q);

    // read data, taken in the setup phase
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata_q <= DBS_RST_WORD;
        end else if (apb_setup) begin
            prdata_q <= 32'h0;
            if (!apb_req.pwrite && mapped) begin
                case (ofs)
                    DBS_OFS_CTRL: prdata_q <= {26'h0, op_size_q, 4'h0};
                    DBS_OFS_ADDR: prdata_q <= addr_reg_q;
                    DBS_OFS_DATA: prdata_q <= data_reg_q;
                    DBS_OFS_STAT: prdata_q <= {30'h0, stat_q};
                    DBS_OFS_IEN: prdata_q <= {30'h0, ien_q};
                    DBS_OFS_STATE: begin
                        prdata_q[DBS_ST_BUSY_BIT] <= (state_q != DBS_IDLE);
                        prdata_q[1] <= misalign_flags[0];
                        prdata_q[DBS_ST_SIZE_LSB +: 2] <= rem_q[1:0];
                        prdata_q[DBS_ST_OFS_LSB +: 2] <= cur_addr_q[1:0];
                        prdata_q[DBS_ST_CNT_LSB +: 8] <= cyc_cnt_q;
                    end
                    default: prdata_q <= 32'h0;
                endcase
            end
        end
    end

endmodule : dbs_write_ctrl

// ---- shared/dbs_pkg.sv ----
// Purpose: constants and carrier types for the write-cycle bus sizing block
// Assumes: 32-bit apb register bus, 32-bit external data bus
// Notes: size codes give bytes still to move, 4 encoded as 00
package dbs_pkg;

    // apb register byte addresses
    localparam logic [7:0] DBS_OFS_CTRL = 8'h00;
    localparam logic [7:0] DBS_OFS_ADDR = 8'h04;
    localparam logic [7:0] DBS_OFS_DATA = 8'h08;
    localparam logic [7:0] DBS_OFS_STAT = 8'h0C;
    localparam logic [7:0] DBS_OFS_CLR = 8'h10;
    localparam logic [7:0] DBS_OFS_IEN = 8'h14;
    localparam logic [7:0] DBS_OFS_STATE = 8'h18;

    // control register fields
    localparam int DBS_CTRL_WRITE_BIT = 0;
    localparam int DBS_CTRL_FETCH_BIT = 1;
    localparam int DBS_CTRL_SIZE_LSB = 4;

    // event bits in status, clear and enable registers
    localparam int DBS_EV_DONE_BIT = 0;
    localparam int DBS_EV_ADDR_ERR_BIT = 1;
    localparam int DBS_EV_WIDTH = 2;

    // state register fields
    localparam int DBS_ST_BUSY_BIT = 0;
    localparam int DBS_ST_SIZE_LSB = 4;
    localparam int DBS_ST_OFS_LSB = 6;
    localparam int DBS_ST_CNT_LSB = 8;

    // reset values
    localparam logic [31:0] DBS_RST_WORD = 32'h0000_0000;
    localparam logic [1:0] DBS_RST_SIZE = 2'h0;
    localparam logic [DBS_EV_WIDTH-1:0] DBS_RST_EV = 2'h0;

    // size codes, bytes still to move
    localparam logic [1:0] DBS_SIZE_BYTE = 2'h1;
    localparam logic [1:0] DBS_SIZE_WORD = 2'h2;
    localparam logic [1:0] DBS_SIZE_THREE = 2'h3;
    localparam logic [1:0] DBS_SIZE_LONG = 2'h0;

    // byte counts
    localparam logic [2:0] DBS_BYTES_LONG = 3'h4;
    localparam logic [2:0] DBS_BYTES_WORD_PORT = 3'h2;
    localparam logic [2:0] DBS_BYTES_BYTE_PORT = 3'h1;

    // external cycle outputs, all from flip-flops
    typedef struct packed {
        logic [31:0] addr;
        logic size_code_high;
        logic size_code_low;
        logic byte_offset_high;
        logic byte_offset_low;
        logic cycle;
        logic read;
        logic [31:0] data;
        logic data_oe;
    } dbs_ext_out_type;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } dbs_apb_req_type;

    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dbs_apb_rsp_type;

endpackage : dbs_pkg

// ---- hw/dbs_lane_mux.sv ----
// Purpose: route operand bytes onto the four data bus lanes for a write
// Assumes: operand right justified, byte 3 is bits 7:0
// Notes: purely combinational, every lane is always given a byte
`timescale 1ns/1ps
module dbs_lane_mux (
    // operand and cycle shape
    input wire logic [31:0] operand,
    input wire logic [1:0] size,
    input wire logic [1:0] offset,
    // lanes 31:24 down to 7:0
    output logic [31:0] lanes
);
    import dbs_pkg::*;

    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;

    assign b0 = operand[31:24];
    assign b1 = operand[23:16];
    assign b2 = operand[15:8];
    assign b3 = operand[7:0];

    always_comb begin
        lanes = {b0, b1, b2, b3};
        case (size)
            DBS_SIZE_BYTE: begin
                lanes = {b3, b3, b3, b3};
            end
            DBS_SIZE_WORD: begin
                if (!offset[0]) begin
                    lanes = {b2, b3, b2, b3};
                end else begin
                    lanes = {b2, b2, b3, b2};
                end
            end
            DBS_SIZE_THREE: begin
                case (offset)
                    2'h0: lanes = {b1, b2, b3, b0};
                    2'h1: lanes = {b1, b1, b2, b3};
                    2'h2: lanes = {b1, b2, b1, b2};
                    default: lanes = {b1, b1, b2, b1};
                endcase
            end
            default: begin
                case (offset)
                    2'h0: lanes = {b0, b1, b2, b3};
                    2'h1: lanes = {b0, b0, b1, b2};
                    2'h2: lanes = {b0, b1, b0, b1};
                    default: lanes = {b0, b0, b1, b0};
                endcase
            end
        endcase
    end

endmodule : dbs_lane_mux

// ---- dv/dbs_write_chk.sv ----
// Purpose: port checker for the write sizing block
// Assumes: sees only the ports of dbs_write_ctrl
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module dbs_write_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb
    input wire dbs_pkg::dbs_apb_req_type apb_req,
    input wire dbs_pkg::dbs_apb_rsp_type apb_rsp,
    // external bus
    input wire dbs_pkg::dbs_ext_out_type ext_out,
    input wire logic port_width_ack_upper,
    input wire logic port_width_ack_lower,
    input wire logic irq
);
    import dbs_pkg::*;
    logic [1:0] sz;
    logic [1:0] of;
    logic [31:0] d;
    logic wr;
    logic ack;
    assign sz = {ext_out.size_code_high, ext_out.size_code_low};
    assign of = {ext_out.byte_offset_high, ext_out.byte_offset_low};
    assign d = ext_out.data;
    assign wr = ext_out.cycle && !ext_out.read;
    assign ack = port_width_ack_upper || port_width_ack_lower;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // repeated-lane pattern shared by offsets 1 to 3
    function automatic logic pat(input logic [1:0] o, input logic [31:0] v);
        if (o == 2'h1) return v[31:24] == v[23:16];
        if (o == 2'h2) return v[31:16] == v[15:0];
        return v[31:24] == v[23:16] && v[31:24] == v[7:0];
    endfunction : pat
    byte_lanes_a: assert property (wr && sz == DBS_SIZE_BYTE |-> d == {4{d[7:0]}})
        else $error("byte lanes differ");
    word_lanes_a: assert property (wr && sz == DBS_SIZE_WORD |-> pat({1'b1, of[0]}, d))
        else $error("word lanes wrong");
    three_lanes_a: assert property (wr && sz == DBS_SIZE_THREE && of != 2'h0 |-> pat(of, d))
        else $error("three-byte lanes wrong");
    long_lanes_a: assert property (wr && sz == DBS_SIZE_LONG && of != 2'h0 |-> pat(of, d))
        else $error("long lanes wrong");
    offset_bits_a: assert property (ext_out.cycle |-> of == ext_out.addr[1:0])
        else $error("offset bits differ from address");
    all_lanes_a: assert property (wr |-> ext_out.data_oe)
        else $error("write lanes not driven");
    cycle_hold_a: assert property (ext_out.cycle && !ack |=>
        ext_out.cycle && $stable(ext_out.addr) && $stable(d))
        else $error("cycle changed before ack");
    ack_close_a: assert property (ext_out.cycle && ack |-> ##[1:2] !ext_out.cycle)
        else $error("cycle not closed after ack");
    odd_long_a: assert property (ext_out.cycle && port_width_ack_upper && port_width_ack_lower &&
        sz == DBS_SIZE_LONG && of == 2'h3 |-> ##[1:3] (ext_out.cycle &&
        sz == DBS_SIZE_THREE && of == 2'h0))
        else $error("no three-byte follow-on");
    cover property (wr && sz == DBS_SIZE_BYTE);
    cover property (ext_out.cycle && port_width_ack_upper && !port_width_ack_lower);
    cover property (ext_out.cycle && port_width_ack_lower && !port_width_ack_upper);
    cover property (irq);
endmodule : dbs_write_chk

bind dbs_write_ctrl dbs_write_chk u_chk (.clk(clk), .rstn(rstn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .ext_out(ext_out), .port_width_ack_upper(port_width_ack_upper),
    .port_width_ack_lower(port_width_ack_lower), .irq(irq));

// ---- dv/dbs_port_model.sv ----
// Purpose: external 8, 16 or 32-bit write port
// Assumes: width 0 is 32, 1 is 16, 2 is 8 bits
// Notes: logs size and address of every cycle
`timescale 1ns/1ps
module dbs_port_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // bus cycle and port setup
    input wire dbs_pkg::dbs_ext_out_type ext_out,
    input wire logic [1:0] width,
    input wire logic [3:0] delay,
    // width acknowledges
    output logic port_width_ack_upper,
    output logic port_width_ack_lower
);
    import dbs_pkg::*;
    logic [7:0] mem [0:15];
    logic [5:0] log_q [0:3];
    int ncyc;
    int lft;
    int bse;
    int tk;
    logic [3:0] wait_q;
    logic seen_q;
    always @(posedge clk) begin
        if (!rstn || !ext_out.cycle) begin
            port_width_ack_upper <= 1'b0;
            port_width_ack_lower <= 1'b0;
            wait_q <= 4'h0;
            seen_q <= 1'b0;
        end else if (port_width_ack_upper || port_width_ack_lower) begin
            port_width_ack_upper <= 1'b0;
            port_width_ack_lower <= 1'b0;
        end else if (!seen_q && wait_q < delay) begin
            wait_q <= wait_q + 4'h1;
        end else if (!seen_q) begin
            // latch what fits, then acknowledge with own width
            seen_q <= 1'b1;
            lft = {ext_out.size_code_high, ext_out.size_code_low};
            lft = (lft == 0) ? 4 : lft;
            bse = (width == 2'h0) ? ext_out.addr[1:0] : (width == 2'h1) ? ext_out.addr[0] : 0;
            tk = (width == 2'h2) ? 1 : (width == 2'h1) ? 2 - bse : 4 - bse;
            tk = (tk > lft) ? lft : tk;
            for (int j = 0; j < tk; j++) begin
                mem[4'(ext_out.addr[3:0] + j)] <= ext_out.data[31 - 8 * (bse + j) -: 8];
            end
            log_q[ncyc % 4] <= {ext_out.size_code_high, ext_out.size_code_low, ext_out.addr[3:0]};
            ncyc++;
            port_width_ack_upper <= (width != 2'h2);
            port_width_ack_lower <= (width != 2'h1);
        end
    end
endmodule : dbs_port_model

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for dbs_write_ctrl
// Assumes: apb master tasks, port model on the external bus
// Notes: operand bytes are compared in the port model memory
`timescale 1ns/1ps
module testbench;
    import dbs_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    dbs_apb_req_type req = '0;
    dbs_apb_rsp_type rsp;
    dbs_ext_out_type ext;
    logic ack_u;
    logic ack_l;
    logic irq;
    logic [1:0] width = 2'h0;
    logic [3:0] delay = 4'h0;
    int err_count = 0;
    int num_checks = 0;
    always #25 clk = ~clk;
    dbs_write_ctrl uut (.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .ext_out(ext),
        .port_width_ack_upper(ack_u), .port_width_ack_lower(ack_l), .irq(irq));
    dbs_port_model u_port (.clk(clk), .rstn(rstn), .ext_out(ext), .width(width), .delay(delay),
        .port_width_ack_upper(ack_u), .port_width_ack_lower(ack_l));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge clk);
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= {24'h0, a};
        req.pwdata <= wd;
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd(DBS_OFS_STAT, r);
        check(r, 32'h0);
        rd(DBS_OFS_STATE, r);
        check(r, 32'h0);
        apb(1'b0, 8'h1C, 32'h0, r, e);
        check({e, r[30:0]}, 32'h8000_0000);
    endtask : t_regs
    task automatic do_op(input logic [1:0] sz, input logic [3:0] ad, input logic [1:0] w,
                         input logic [3:0] n, input logic [17:0] lg);
        logic [31:0] r;
        int k;
        int nb;
        width <= w;
        delay <= {2'h0, ad[1:0]};
        for (k = 0; k < 16; k++) u_port.mem[k] = 8'h00;
        for (k = 0; k < 4; k++) u_port.log_q[k] = 6'h00;
        u_port.ncyc = 0;
        wr(DBS_OFS_ADDR, {28'h0, ad});
        wr(DBS_OFS_DATA, 32'h1122_3344);
        wr(DBS_OFS_CTRL, {26'h0, sz, 4'h1});
        k = 0;
        do begin
            rd(DBS_OFS_STAT, r);
            k++;
        end while (r[DBS_EV_DONE_BIT] !== 1'b1 && k < 60);
        check({31'h0, r[DBS_EV_DONE_BIT]}, 32'h1);
        nb = (sz == DBS_SIZE_LONG) ? 4 : int'(sz);
        for (k = 0; k < nb; k++) begin
            check({24'h0, u_port.mem[4'(ad + k)]}, 32'h1122_3344 >> (8 * (nb - 1 - k)) & 32'hFF);
        end
        rd(DBS_OFS_STATE, r);
        check({24'h0, r[15:8]}, {28'h0, n});
        check({14'h0, u_port.log_q[0], u_port.log_q[1], u_port.log_q[2]}, {14'h0, lg});
        wr(DBS_OFS_CLR, 32'h3);
    endtask : do_op
    task automatic t_sizing();
        do_op(DBS_SIZE_BYTE, 4'h3, 2'h0, 4'h1, {6'h13, 6'h00, 6'h00});
        do_op(DBS_SIZE_WORD, 4'h1, 2'h1, 4'h2, {6'h21, 6'h12, 6'h00});
        do_op(DBS_SIZE_WORD, 4'h0, 2'h2, 4'h2, {6'h20, 6'h11, 6'h00});
        do_op(DBS_SIZE_WORD, 4'h3, 2'h0, 4'h2, {6'h23, 6'h14, 6'h00});
        do_op(DBS_SIZE_LONG, 4'h0, 2'h1, 4'h2, {6'h00, 6'h22, 6'h00});
        do_op(DBS_SIZE_LONG, 4'h1, 2'h1, 4'h3, {6'h01, 6'h32, 6'h14});
        do_op(DBS_SIZE_LONG, 4'h3, 2'h0, 4'h2, {6'h03, 6'h34, 6'h00});
        do_op(DBS_SIZE_LONG, 4'h2, 2'h0, 4'h2, {6'h02, 6'h24, 6'h00});
        do_op(DBS_SIZE_THREE, 4'h2, 2'h1, 4'h2, {6'h32, 6'h14, 6'h00});
        do_op(DBS_SIZE_THREE, 4'h1, 2'h0, 4'h1, {6'h31, 6'h00, 6'h00});
    endtask : t_sizing
    task automatic t_align();
        logic [31:0] r;
        logic [1:0] sz;
        for (int i = 0; i < 12; i++) begin
            sz = (i < 4) ? DBS_SIZE_BYTE : (i < 8) ? DBS_SIZE_WORD : DBS_SIZE_LONG;
            wr(DBS_OFS_ADDR, 32'(i % 4));
            wr(DBS_OFS_CTRL, {26'h0, sz, 4'h0});
            rd(DBS_OFS_STATE, r);
            check({31'h0, r[1]}, {31'h0, (i >= 4) && (i < 8 ? i % 2 == 1 : i % 4 != 0)});
        end
    endtask : t_align
    task automatic t_prefetch();
        logic [31:0] r;
        int k;
        u_port.ncyc = 0;
        wr(DBS_OFS_IEN, 32'h2);
        wr(DBS_OFS_ADDR, 32'h1);
        wr(DBS_OFS_CTRL, 32'h2);
        rd(DBS_OFS_STAT, r);
        check(r, 32'h2);
        check({31'h0, irq}, 32'h1);
        check(32'(u_port.ncyc), 32'h0);
        wr(DBS_OFS_IEN, 32'h0);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        wr(DBS_OFS_IEN, 32'h2);
        wr(DBS_OFS_CLR, 32'h2);
        rd(DBS_OFS_STAT, r);
        check({r[30:0], irq}, 32'h0);
        width <= 2'h1;
        wr(DBS_OFS_ADDR, 32'h4);
        wr(DBS_OFS_CTRL, 32'h2);
        k = 0;
        do begin
            rd(DBS_OFS_STAT, r);
            k++;
        end while (r[DBS_EV_DONE_BIT] !== 1'b1 && k < 60);
        check(r, 32'h1);
        check(32'(u_port.ncyc), 32'h2);
    endtask : t_prefetch
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_sizing();
        t_align();
        t_prefetch();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule : testbench
